// ==== logic/msg_ind_consts.svh ====
// constants for the receive-message indication block
// Notes on behaviour
// (RULE1) when enabled, a received message drives a 5-bit kind and pulses the strobe
// (RULE2) strobe length depends on the message kind and, for vendor kinds, on has_payload
// (RULE3) each strobe cycle carries one parameter byte in kind-specific order
// (RULE4) vendor-defined messages pass only the first payload dword
// (RULE5) user logic wanting longer vendor payloads uses the completer request path
// (RULE6) codes 0-2 errors, 3-10 interrupt lines, 11-14 power, 15 slot power
// (RULE7) code 16 latency tolerance, code 18 unlock
// (RULE8) 17 flush hint, 19-20 vendor, 21-24 translation; 25-31 never emitted
// (RULE9) error, interrupt, power, unlock, translation: 2 cycles, bus then devfn
// (RULE10) slot power: 6 cycles, bus, devfn, payload bytes low first
// (RULE11) latency: 6 cycles, bus, devfn, snoop low/high, no-snoop low/high
// (RULE12) flush hint: 3 cycles, bus, devfn, hint code
// (RULE13) vendor: 4 cycles bare or 8 with payload, low byte first
// (RULE14) at least one idle cycle between strobe pulses
// (RULE15) user logic accepts every indication; no stall exists
// (RULE16) kind code stays stable throughout a strobe pulse
`ifndef MSG_IND_CONSTS_SVH
`define MSG_IND_CONSTS_SVH
`define KIND_ERR_FATAL 5'h02
`define KIND_PM_LAST 5'h0E
`define KIND_SLOT_PWR 5'h0F
`define KIND_LTR 5'h10
`define KIND_OBFF 5'h11
`define KIND_UNLOCK 5'h12
`define KIND_VEND0 5'h13
`define KIND_VEND1 5'h14
`define KIND_ATS_LAST 5'h18
`define LEN_SHORT 4'h2
`define LEN_HINT 4'h3
`define LEN_VEND_BARE 4'h4
`define LEN_SIX 4'h6
`define LEN_VEND_DATA 4'h8
`define IDX_BUS 3'h0
`define IDX_DEVFN 3'h1
`define IDX_B2 3'h2
`define IDX_B3 3'h3
`define IDX_B4 3'h4
`define IDX_B5 3'h5
`define IDX_B6 3'h6
`define FIFO_DEPTH 16
`endif

// ==== logic/msg_ind_pkg.sv ====
// types shared by the receive-message indication block
package msg_ind_pkg;
  typedef struct packed {
    logic [4:0] kind;
    logic [7:0] req_bus;
    logic [7:0] req_devfn;
    logic [15:0] vendor_id;
    logic [31:0] payload;
    logic has_payload;
  } msg_rec_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01,
    ST_GAP = 2'b11
  } ind_state_t;
endpackage

// ==== logic/msg_fifo.sv ====
// parameterised valid/ready fifo
`timescale 1ns/1ps
module msg_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } fifo_state_t;
  fifo_state_t s_r;
  fifo_state_t s_nxt;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign in_ready = s_r.cnt != (AW+1)'(DEPTH);
  assign out_valid = s_r.cnt != '0;
  assign out_data = mem[s_r.rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.wr = AW'(s_r.wr + 1'b1);
    end
    if (pop) begin
      s_nxt.rd = AW'(s_r.rd + 1'b1);
    end
    s_nxt.cnt = (AW+1)'(s_r.cnt + push - pop);
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // storage has no reset; only the pointers and the count need a defined value
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[s_r.wr] <= in_data;
    end
  end
endmodule

// ==== logic/msg_ind.sv ====
// receive-message indication: queues messages, serialises parameters
`timescale 1ns/1ps
`include "msg_ind_consts.svh"
module msg_ind (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic ind_enable,
  input wire msg_ind_pkg::msg_rec_t msg_in,
  input wire logic msg_in_valid,
  output logic msg_in_ready,
  output logic [4:0] msg_kind,
  output logic msg_strobe,
  output logic [7:0] msg_data
);
  typedef struct packed {
    msg_ind_pkg::ind_state_t st;
    msg_ind_pkg::msg_rec_t cur;
    logic [3:0] len;
    logic [3:0] idx;
    logic [4:0] kind;
    logic strobe;
    logic [7:0] data;
  } ind_t;
  ind_t s_r;
  ind_t s_nxt;
  msg_ind_pkg::msg_rec_t q_data;
  logic q_valid;
  logic q_ready;
  logic legal;

  // only legal kinds enter; reserved codes are dropped at the input
  assign legal = msg_in.kind <= `KIND_ATS_LAST; // RULE8

  msg_fifo #(
    .WIDTH($bits(msg_ind_pkg::msg_rec_t)),
    .DEPTH(`FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .in_data(msg_in),
    .in_valid(msg_in_valid && legal && ind_enable), // RULE1
    .in_ready(msg_in_ready),
    .out_data(q_data),
    .out_valid(q_valid),
    .out_ready(q_ready)
  );

  assign q_ready = s_r.st == msg_ind_pkg::ST_IDLE;

  function automatic logic [3:0] len_of(input msg_ind_pkg::msg_rec_t m);
    logic [3:0] n;
    n = `LEN_SHORT; // RULE9
    unique case (m.kind)
      `KIND_SLOT_PWR: n = `LEN_SIX; // RULE10
      `KIND_LTR: n = `LEN_SIX; // RULE11
      `KIND_OBFF: n = `LEN_HINT; // RULE12
      `KIND_VEND0, `KIND_VEND1: begin
        n = m.has_payload ? `LEN_VEND_DATA : `LEN_VEND_BARE; // RULE13
      end
      default: n = `LEN_SHORT; // RULE9
    endcase
    return n; // RULE2
  endfunction

  // byte order per kind; payload holds one dword only, the rest dropped
  function automatic logic [7:0] byte_of(input msg_ind_pkg::msg_rec_t m,
                                         input logic [2:0] i);
    logic [7:0] b;
    b = 8'h00;
    if (i == `IDX_BUS) begin
      b = m.req_bus;
    end else if (i == `IDX_DEVFN) begin
      b = m.req_devfn;
    end else if (m.kind == `KIND_VEND0 || m.kind == `KIND_VEND1) begin
      unique case (i)
        `IDX_B2: b = m.vendor_id[7:0];
        `IDX_B3: b = m.vendor_id[15:8];
        `IDX_B4: b = m.payload[7:0]; // RULE4
        `IDX_B5: b = m.payload[15:8];
        `IDX_B6: b = m.payload[23:16];
        default: b = m.payload[31:24];
      endcase
    end else begin
      // slot power, latency (snoop in low half) and hint share layout
      unique case (i)
        `IDX_B2: b = m.payload[7:0]; // RULE10
        `IDX_B3: b = m.payload[15:8]; // RULE11
        `IDX_B4: b = m.payload[23:16];
        default: b = m.payload[31:24];
      endcase
    end
    return b; // RULE3
  endfunction

  always_comb begin
    s_nxt = s_r;
    unique case (s_r.st)
      msg_ind_pkg::ST_IDLE: begin
        s_nxt.strobe = 1'b0;
        if (q_valid) begin
          s_nxt.st = msg_ind_pkg::ST_SEND;
          s_nxt.cur = q_data;
          s_nxt.len = len_of(q_data);
          s_nxt.idx = {1'b0, `IDX_DEVFN};
          s_nxt.kind = q_data.kind; // RULE6 RULE7
          s_nxt.strobe = 1'b1; // RULE1
          s_nxt.data = byte_of(q_data, `IDX_BUS);
        end
      end
      msg_ind_pkg::ST_SEND: begin
        // kind is left untouched during the pulse
        // four-bit index so an eight-byte pulse can reach its end count
        if (s_r.idx == s_r.len) begin // RULE16
          s_nxt.st = msg_ind_pkg::ST_GAP;
          s_nxt.strobe = 1'b0;
          s_nxt.data = 8'h00;
        end else begin
          s_nxt.data = byte_of(s_r.cur, s_r.idx[2:0]); // RULE3
          s_nxt.idx = 4'(s_r.idx + 1'b1);
        end
      end
      msg_ind_pkg::ST_GAP: begin
        // one forced idle cycle here, then one more in ST_IDLE, so two idle cycles before the next pulse
        s_nxt.st = msg_ind_pkg::ST_IDLE; // RULE14
      end
      default: begin
        s_nxt.st = msg_ind_pkg::ST_IDLE;
        s_nxt.strobe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // user side has no stall; indications are simply presented
  assign msg_kind = s_r.kind; // RULE15
  assign msg_strobe = s_r.strobe;
  assign msg_data = s_r.data;
endmodule

// ==== tb/msg_ind_chk.sv ====
// assertion checker for the message indication block
`timescale 1ns/1ps
module msg_ind_chk (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic ind_enable,
  input wire msg_ind_pkg::msg_rec_t msg_in,
  input wire logic msg_in_valid,
  input wire logic msg_in_ready,
  input wire logic [4:0] msg_kind,
  input wire logic msg_strobe,
  input wire logic [7:0] msg_data
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  wire logic s = msg_strobe;
  wire logic [4:0] k = msg_kind;
  AST_STABLE: assert property (s && $past(s) |-> $stable(k))
    else $error("kind moved");
  AST_GAP: assert property ($fell(s) |=> !s)
    else $error("no gap");
  AST_RSV: assert property (s |-> k <= 5'h18)
    else $error("reserved kind");
  AST_LEN2: assert property ($rose(s) && (k <= 5'h0E || k == 5'h12 ||
    k >= 5'h15) |-> s[*2] ##1 !s) else $error("short len");
  AST_LEN6: assert property ($rose(s) && k inside {5'h0F, 5'h10}
    |-> s[*6] ##1 !s) else $error("six len");
  AST_LEN3: assert property ($rose(s) && k == 5'h11 |-> s[*3] ##1 !s)
    else $error("hint len");
  AST_VEND: assert property ($rose(s) && k inside {5'h13, 5'h14}
    |-> s[*4] ##1 (!s or s[*4] ##1 !s)) else $error("vendor len");
  AST_TAKE: assert property (msg_in_valid && msg_in_ready && ind_enable
    && msg_in.kind <= 5'h18 |-> ##[1:400] $rose(s)) else $error("no pulse");
  cover property ($rose(s) && k == 5'h13);
  cover property ($rose(s) && k == 5'h0F);
  cover property (msg_in_valid && !msg_in_ready);
endmodule
bind msg_ind msg_ind_chk u_chk (.core_clk(core_clk), .rst_b(rst_b),
  .ind_enable(ind_enable), .msg_in(msg_in), .msg_in_valid(msg_in_valid),
  .msg_in_ready(msg_in_ready), .msg_kind(msg_kind),
  .msg_strobe(msg_strobe), .msg_data(msg_data));

// ==== tb/msg_user.sv ====
// user-side model: takes every indication byte, it cannot stall
// longer vendor payloads are fetched elsewhere, never here
`timescale 1ns/1ps
module msg_user (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic msg_strobe,
  input wire logic [4:0] msg_kind,
  input wire logic [7:0] msg_data,
  output logic got_v_r,
  output logic [12:0] got_r
);
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      got_v_r <= 1'b0;
      got_r <= 13'h0000;
    end else begin
      got_v_r <= msg_strobe;
      got_r <= {msg_kind, msg_data};
    end
  end
endmodule

// ==== tb/msg_ind_tb.sv ====
// self-checking bench for the message indication block
`timescale 1ns/1ps
module msg_ind_tb;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic ind_enable = 1'b1;
  msg_ind_pkg::msg_rec_t msg_in = '0;
  logic msg_in_valid = 1'b0;
  logic msg_in_ready, msg_strobe, got_v;
  logic [4:0] msg_kind;
  logic [7:0] msg_data;
  logic [12:0] got, e;
  logic [12:0] q[$];
  int n_errors = 0;
  int checks = 0;
  always #5 core_clk = ~core_clk;
  msg_ind u_dut (.core_clk(core_clk), .rst_b(rst_b), .ind_enable(ind_enable),
    .msg_in(msg_in), .msg_in_valid(msg_in_valid), .msg_in_ready(msg_in_ready),
    .msg_kind(msg_kind), .msg_strobe(msg_strobe), .msg_data(msg_data));
  msg_user u_user (.core_clk(core_clk), .rst_b(rst_b), .msg_strobe(msg_strobe),
    .msg_kind(msg_kind), .msg_data(msg_data), .got_v_r(got_v), .got_r(got));
  task automatic close_out();
    if (n_errors == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic send(input logic [4:0] k, input logic hp);
    msg_ind_pkg::msg_rec_t m;
    m = {k, 8'($urandom), 8'($urandom), 16'($urandom), $urandom, hp};
    @(posedge core_clk);
    msg_in <= m;
    msg_in_valid <= 1'b1;
    do @(negedge core_clk); while (msg_in_ready !== 1'b1);
    @(posedge core_clk);
    msg_in_valid <= 1'b0;
    if (ind_enable && k <= 5'h18) begin
      q.push_back({k, m.req_bus});
      q.push_back({k, m.req_devfn});
      if (k inside {5'h13, 5'h14}) begin
        q.push_back({k, m.vendor_id[7:0]});
        q.push_back({k, m.vendor_id[15:8]});
      end
      if (k == 5'h11)
        q.push_back({k, m.payload[7:0]});
      if (k inside {5'h0F, 5'h10} || (hp && k inside {5'h13, 5'h14}))
        for (int i = 0; i < 4; i++)
          q.push_back({k, m.payload[i*8 +: 8]});
    end
  endtask
  always @(negedge core_clk) begin
    if (got_v === 1'b1) begin
      e = (q.size() > 0) ? q.pop_front() : 13'h1FFF;
      checks++;
      if (got !== e) begin
        n_errors++;
        $display("[FAIL] byte exp %h got %h", e, got);
      end
    end
  end
  initial begin
    void'($urandom(69));
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    @(negedge core_clk);
    checks++;
    if (msg_in_ready !== 1'b1) begin
      n_errors++;
      $display("[FAIL] ready exp 1 got %b", msg_in_ready);
    end
    // second pass sends vendor kinds with payload; back-to-back fills fifo
    for (int r = 0; r < 2; r++)
      for (int k = 0; k < 26; k++)
        send(5'(k), r[0]);
    ind_enable <= 1'b0;
    send(5'h03, 1'b0);
    ind_enable <= 1'b1;
    for (int i = 0; i < 3000 && q.size() > 0; i++)
      @(posedge core_clk);
    repeat (4) @(posedge core_clk);
    checks++;
    if (q.size() != 0) begin
      n_errors++;
      $display("[FAIL] left exp 0 got %0d", q.size());
    end
    close_out();
  end
  initial begin
    #200000;
    n_errors++;
    close_out();
  end
endmodule
